/* mfc_pkg.sv */
// shared constants for the miscellaneous feature control block
package mfc_pkg;
   // clock
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned MS_PER_S = 1000;
   // register map, byte addresses on the serial port
   localparam logic [5:0] MFC_ADDR_LO = 6'h34;
   localparam logic [5:0] MFC_ADDR_HI = 6'h35;
   localparam logic [15:0] MFC_RESET = 16'h0000;
   // field positions
   localparam int unsigned BIT_RDY_PIN = 0;
   localparam int unsigned BIT_RDY_POL = 1;
   localparam int unsigned BIT_RDY_EN = 2;
   localparam int unsigned BIT_CHK_EN = 8;
   localparam int unsigned BIT_REV = 9;
   localparam int unsigned BIT_NO_BOOT_CHK = 10;
   localparam logic [15:0] MFC_USED_MASK = 16'h0707;
   // self-check duration
   localparam int unsigned CHK_HP_TIME_MS = 13;
   localparam int unsigned CHK_LP_TIME_MS = 35;
   localparam int unsigned CHK_HP_CYC = CHK_HP_TIME_MS * (CLK_HZ / MS_PER_S);
   localparam int unsigned CHK_LP_CYC = CHK_LP_TIME_MS * (CLK_HZ / MS_PER_S);
   localparam int unsigned CHK_CNT_W = 21;
   // inclination format, 0.025 degree per lsb
   localparam int unsigned INCL_W = 14;
   localparam logic [13:0] INCL_37_DEG = 14'h05c8;
   localparam logic [13:0] INCL_FULL_TURN = 14'h3840;
   localparam logic [13:0] INCL_ZERO = 14'h0000;
   // sample period setting
   localparam int unsigned SMPL_W = 8;
   localparam logic [7:0] SMPL_CHK_FAST = 8'h01;
   // data-ready pulse: trailing edge at a quarter of the measured period
   localparam int unsigned RDY_SHIFT = 2;
   localparam int unsigned RDY_CNT_W = 24;
   // self-check states
   typedef enum logic {
      CHK_IDLE = 1'b0,
      CHK_RUN = 1'b1
   } mfc_chk_state_t;
endpackage

/* mfc_misc_ctrl.sv */
// miscellaneous feature control: data-ready pin, pin priority, rotation, self-check
`timescale 1ns/10ps
module mfc_misc_ctrl #(
   parameter int unsigned CHK_HP_CYCLES = mfc_pkg::CHK_HP_CYC,
   parameter int unsigned CHK_LP_CYCLES = mfc_pkg::CHK_LP_CYC
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_sw_reset,
   input wire logic i_wr_en,
   input wire logic [5:0] i_wr_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic [5:0] i_rd_addr,
   output logic [7:0] o_rd_data,
   input wire logic i_sample_done,
   input wire logic [1:0] i_alarm_oe,
   input wire logic [1:0] i_alarm_out,
   input wire logic [1:0] i_gpio_oe,
   input wire logic [1:0] i_gpio_out,
   output logic [1:0] o_aux_pin_out,
   output logic [1:0] o_aux_pin_oe,
   input wire logic [mfc_pkg::INCL_W-1:0] i_incl_raw,
   output logic [mfc_pkg::INCL_W-1:0] o_incl,
   input wire logic i_low_power,
   input wire logic i_self_check_ok,
   input wire logic i_clear_status,
   output logic o_self_check_active,
   output logic o_self_check_fail,
   input wire logic [mfc_pkg::SMPL_W-1:0] i_sample_period_setting,
   output logic [mfc_pkg::SMPL_W-1:0] o_sample_period_setting
);
   import mfc_pkg::*;

   function automatic logic [INCL_W-1:0] incl_reverse(input logic [INCL_W-1:0] a);
      if (a == INCL_ZERO) begin
         incl_reverse = INCL_ZERO;
      end else begin
         incl_reverse = INCL_FULL_TURN - a;
      end
   endfunction

   // ---------------- register ----------------
   logic [15:0] ctrl_q, ctrl_d;
   logic [7:0] rd_q, rd_d;
   logic chk_done;

   always_comb begin
      ctrl_d = ctrl_q;
      if (i_wr_en && i_wr_addr == MFC_ADDR_LO) begin
         ctrl_d[7:0] = i_wr_data & MFC_USED_MASK[7:0];
      end
      if (i_wr_en && i_wr_addr == MFC_ADDR_HI) begin
         ctrl_d[15:8] = i_wr_data & MFC_USED_MASK[15:8];
      end
      if (i_sw_reset) begin
         ctrl_d[BIT_CHK_EN] = 1'b0;
      end
      if (i_rd_addr == MFC_ADDR_LO) begin
         rd_d = ctrl_q[7:0];
      end else if (i_rd_addr == MFC_ADDR_HI) begin
         rd_d = ctrl_q[15:8];
      end else begin
         rd_d = 8'h00;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ctrl_q <= MFC_RESET;
         rd_q <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
         rd_q <= rd_d;
      end
   end

   assign o_rd_data = rd_q;

   wire rdy_en = ctrl_q[BIT_RDY_EN];
   wire rdy_pol = ctrl_q[BIT_RDY_POL];
   wire rdy_sel = ctrl_q[BIT_RDY_PIN];

   // ---------------- data-ready pulse ----------------
   logic rdy_act_q, rdy_act_d;
   logic [RDY_CNT_W-1:0] cnt_q, cnt_d, per_q, per_d;
   logic [RDY_CNT_W-1:0] rdy_limit;

   always_comb begin
      rdy_limit = per_q >> RDY_SHIFT;
      if (rdy_limit == '0) begin
         rdy_limit = {{(RDY_CNT_W-1){1'b0}}, 1'b1};
      end
      cnt_d = cnt_q;
      per_d = per_q;
      rdy_act_d = rdy_act_q;
      if (i_sample_done) begin
         per_d = cnt_q;
         cnt_d = '0;
         rdy_act_d = 1'b1;
      end else begin
         if (cnt_q != '1) begin
            cnt_d = cnt_q + 1'b1;
         end
         if (cnt_q >= rdy_limit) begin
            rdy_act_d = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         rdy_act_q <= 1'b0;
         cnt_q <= '0;
         per_q <= '0;
      end else begin
         rdy_act_q <= rdy_act_d;
         cnt_q <= cnt_d;
         per_q <= per_d;
      end
   end

   // ---------------- pin priority ----------------
   logic [1:0] pin_out_d, pin_oe_d, pin_out_q, pin_oe_q;

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (rdy_en && rdy_sel == i[0]) begin
            pin_oe_d[i] = 1'b1;
            pin_out_d[i] = rdy_act_q ? rdy_pol : ~rdy_pol;
         end else if (i_alarm_oe[i]) begin
            pin_oe_d[i] = 1'b1;
            pin_out_d[i] = i_alarm_out[i];
         end else begin
            pin_oe_d[i] = i_gpio_oe[i];
            pin_out_d[i] = i_gpio_out[i];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         pin_out_q <= 2'b00;
         pin_oe_q <= 2'b00;
      end else begin
         pin_out_q <= pin_out_d;
         pin_oe_q <= pin_oe_d;
      end
   end

   assign o_aux_pin_out = pin_out_q;
   assign o_aux_pin_oe = pin_oe_q;

   // ---------------- self-check ----------------
   mfc_chk_state_t chk_q, chk_d;
   logic boot_q, boot_d;
   logic [CHK_CNT_W-1:0] chk_cnt_q, chk_cnt_d, chk_len;
   logic fail_q, fail_d;
   logic [SMPL_W-1:0] smpl_q, smpl_d, saved_q, saved_d;

   always_comb begin
      chk_len = i_low_power ? CHK_CNT_W'(CHK_LP_CYCLES) : CHK_CNT_W'(CHK_HP_CYCLES);
      chk_d = chk_q;
      chk_cnt_d = chk_cnt_q;
      boot_d = boot_q | i_sw_reset;
      saved_d = saved_q;
      chk_done = 1'b0;
      case (chk_q)
         CHK_IDLE: begin
            if ((boot_q && !ctrl_q[BIT_NO_BOOT_CHK]) || ctrl_q[BIT_CHK_EN]) begin
               chk_d = CHK_RUN;
               chk_cnt_d = '0;
               saved_d = i_sample_period_setting;
            end
            if (!i_sw_reset) begin
               boot_d = 1'b0;
            end
         end
         CHK_RUN: begin
            chk_cnt_d = chk_cnt_q + 1'b1;
            if (chk_cnt_q >= chk_len - 1'b1) begin
               chk_done = 1'b1;
               chk_d = CHK_IDLE;
            end
         end
         default: begin
            chk_d = CHK_IDLE;
         end
      endcase
      fail_d = fail_q;
      if (i_clear_status) begin
         fail_d = 1'b0;
      end
      if (chk_done) begin
         fail_d = ~i_self_check_ok;
      end
      if (chk_d == CHK_RUN) begin
         smpl_d = SMPL_CHK_FAST;
      end else if (chk_q == CHK_RUN) begin
         smpl_d = saved_q;
      end else begin
         smpl_d = i_sample_period_setting;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         chk_q <= CHK_IDLE;
         chk_cnt_q <= '0;
         boot_q <= 1'b1;
         fail_q <= 1'b0;
         saved_q <= '0;
         smpl_q <= '0;
      end else begin
         chk_q <= chk_d;
         chk_cnt_q <= chk_cnt_d;
         boot_q <= boot_d;
         fail_q <= fail_d;
         saved_q <= saved_d;
         smpl_q <= smpl_d;
      end
   end

   assign o_self_check_active = (chk_q == CHK_RUN);
   assign o_self_check_fail = fail_q;
   assign o_sample_period_setting = smpl_q;

   // ---------------- inclination output ----------------
   logic [INCL_W-1:0] incl_q, incl_d;

   always_comb begin
      if (chk_q == CHK_RUN) begin
         incl_d = INCL_37_DEG;
      end else if (ctrl_q[BIT_REV]) begin
         incl_d = incl_reverse(i_incl_raw);
      end else begin
         incl_d = i_incl_raw;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         incl_q <= '0;
      end else begin
         incl_q <= incl_d;
      end
   end

   assign o_incl = incl_q;

   // ---------------- checks ----------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   AST_RDY_RISE: assert property (
      i_sample_done && rdy_en && !i_wr_en
      |=> ##1 o_aux_pin_oe[$past(rdy_sel)] && o_aux_pin_out[$past(rdy_sel)] == $past(rdy_pol))
      else $error("data-ready pin not active after sample done");

   AST_RDY_FALL: assert property (
      rdy_act_q && !i_sample_done && cnt_q >= rdy_limit |=> !rdy_act_q)
      else $error("data-ready pulse not ended in next cycle");

   AST_PRIO: assert property (
      rdy_en && !i_wr_en && !i_sw_reset |=> o_aux_pin_oe[$past(rdy_sel)])
      else $error("data-ready lost pin priority");

   AST_ALARM_OVER_GPIO: assert property (
      !rdy_en && i_alarm_oe[0] |=> o_aux_pin_oe[0] && o_aux_pin_out[0] == $past(i_alarm_out[0]))
      else $error("alarm did not win pin zero");

   AST_FAIL: assert property (
      chk_done |=> o_self_check_fail == !$past(i_self_check_ok))
      else $error("self-check result not reported");

   AST_37: assert property (
      o_self_check_active |=> o_incl == INCL_37_DEG)
      else $error("inclination not forced during self-check");

   AST_SMPL: assert property (
      chk_q == CHK_RUN && chk_d == CHK_IDLE |=> o_sample_period_setting == $past(saved_q))
      else $error("sample period not restored");

   AST_SWRST: assert property (
      i_sw_reset |=> !ctrl_q[BIT_CHK_EN] && ctrl_q[2:0] == $past(ctrl_d[2:0]))
      else $error("soft reset handled config bits wrongly");

   AST_REV: assert property (
      ctrl_q[BIT_REV] && chk_d == CHK_IDLE && chk_q == CHK_IDLE && i_incl_raw != INCL_ZERO
      |=> o_incl == INCL_FULL_TURN - $past(i_incl_raw))
      else $error("reverse rotation wrong");

   AST_UNUSED: assert property (
      i_rd_addr == MFC_ADDR_HI |=> o_rd_data[7:3] == 5'h00)
      else $error("unused bits read nonzero");

endmodule // mfc_misc_ctrl

/* mfc_sample_src.sv */
// sample cycle source standing in for the converter side
`timescale 1ns/10ps
module mfc_sample_src (
   input wire logic i_clk,
   input wire logic i_en,
   input wire logic [7:0] i_period,
   output logic o_done
);
   int cnt = 0;
   // one done pulse per period while enabled
   initial begin
      o_done = 1'b0;
      forever begin
         @(posedge i_clk);
         #1;
         cnt = (i_en && cnt + 1 < i_period) ? cnt + 1 : 0;
         o_done = i_en && cnt == 0;
      end
   end
endmodule // mfc_sample_src

/* mfc_misc_ctrl_tb.sv */
// self-checking bench for the miscellaneous feature control block
`timescale 1ns/10ps
module mfc_misc_ctrl_tb;
   import mfc_pkg::*;
   localparam int HP = 20;
   localparam int LP = 40;
   logic i_clk, i_nrst, i_sw_reset, i_wr_en, i_low_power, i_self_check_ok, i_clear_status;
   logic [5:0] i_wr_addr, i_rd_addr;
   logic [7:0] i_wr_data, o_rd_data, i_sample_period_setting, o_sample_period_setting;
   logic [1:0] i_alarm_oe, i_alarm_out, i_gpio_oe, i_gpio_out, o_aux_pin_out, o_aux_pin_oe;
   logic [INCL_W-1:0] i_incl_raw, o_incl;
   logic o_self_check_active, o_self_check_fail, i_sample_done, src_en;
   int fail_count = 0;
   int samples_checked = 0;
   int n, raw, sel, pol;
   mfc_misc_ctrl #(.CHK_HP_CYCLES(HP), .CHK_LP_CYCLES(LP)) mfc_misc_ctrl_inst (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_sw_reset(i_sw_reset),
      .i_wr_en(i_wr_en),
      .i_wr_addr(i_wr_addr),
      .i_wr_data(i_wr_data),
      .i_rd_addr(i_rd_addr),
      .o_rd_data(o_rd_data),
      .i_sample_done(i_sample_done),
      .i_alarm_oe(i_alarm_oe),
      .i_alarm_out(i_alarm_out),
      .i_gpio_oe(i_gpio_oe),
      .i_gpio_out(i_gpio_out),
      .o_aux_pin_out(o_aux_pin_out),
      .o_aux_pin_oe(o_aux_pin_oe),
      .i_incl_raw(i_incl_raw),
      .o_incl(o_incl),
      .i_low_power(i_low_power),
      .i_self_check_ok(i_self_check_ok),
      .i_clear_status(i_clear_status),
      .o_self_check_active(o_self_check_active),
      .o_self_check_fail(o_self_check_fail),
      .i_sample_period_setting(i_sample_period_setting),
      .o_sample_period_setting(o_sample_period_setting)
   );
   mfc_sample_src mfc_sample_src_inst (.i_clk(i_clk), .i_en(src_en), .i_period(8'h28),
      .o_done(i_sample_done));
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   task automatic tick(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      i_wr_en = 1'b1;
      i_wr_addr = a;
      i_wr_data = v;
      tick(1);
      i_wr_en = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      i_rd_addr = a;
      tick(1);
      chk({8'h00, o_rd_data}, {8'h00, e});
   endtask
   task automatic sw_rst();
      i_sw_reset = 1'b1;
      tick(1);
      i_sw_reset = 1'b0;
   endtask
   // model of the lower-priority pin owners
   function automatic logic [15:0] mux(int p);
      if (i_alarm_oe[p]) return 16'h0002 | 16'(i_alarm_out[p]);
      return 16'({i_gpio_oe[p], i_gpio_oe[p] & i_gpio_out[p]});
   endfunction
   function automatic logic [15:0] pin(int p);
      return 16'({o_aux_pin_oe[p], o_aux_pin_oe[p] & o_aux_pin_out[p]});
   endfunction
   // k 0: self-check level v, k 1: pin p driven at v
   task automatic wait_for(input int k, input int p, input logic v, output int c);
      c = 0;
      while (k == 0 ? o_self_check_active !== v : pin(p) !== 16'({1'b1, v})) begin
         if (c++ > 3000) begin
            fail_count++;
            complete_run();
         end
         tick(1);
      end
   endtask
   initial begin
      n = $urandom(7003);
      i_nrst = 1'b0;
      {i_sw_reset, i_wr_en, i_low_power, i_self_check_ok, i_clear_status, src_en} = '0;
      {i_wr_addr, i_rd_addr, i_wr_data} = '0;
      {i_alarm_oe, i_alarm_out, i_gpio_oe, i_gpio_out} = '0;
      i_incl_raw = 14'h0123;
      i_sample_period_setting = 8'h2a;
      tick(12);
      i_nrst = 1'b1;
      wait_for(0, 0, 1'b1, n);
      tick(2);
      chk(16'(o_incl), 16'(INCL_37_DEG));
      chk(16'(o_sample_period_setting), 16'(SMPL_CHK_FAST));
      wait_for(0, 0, 1'b0, n);
      chk(16'(n + 2), 16'(HP));
      rd(6'h34, 8'h00);
      rd(6'h35, 8'h00);
      chk(16'(o_sample_period_setting), 16'(i_sample_period_setting));
      chk(16'(o_self_check_fail), 16'h0001);
      i_clear_status = 1'b1;
      tick(1);
      i_clear_status = 1'b0;
      tick(1);
      chk(16'(o_self_check_fail), 16'h0000);
      $display("test boot done");
      for (int i = 0; i < 8; i++) begin
         raw = $urandom;
         wr(6'h34, raw[7:0]);
         wr(6'h35, raw[15:8] & 8'hfe);
         wr(6'h36, 8'hff);
         rd(6'h34, raw[7:0] & MFC_USED_MASK[7:0]);
         rd(6'h35, raw[15:8] & MFC_USED_MASK[15:8] & 8'hfe);
         rd(6'h36, 8'h00);
      end
      $display("test registers done");
      wr(6'h35, 8'h06);
      for (int i = 0; i < 9; i++) begin
         raw = (i == 0) ? 0 : $urandom_range(14399, 1);
         i_incl_raw = 14'(raw);
         tick(3);
         chk(16'(o_incl), 16'((raw == 0) ? 0 : 14400 - raw));
      end
      wr(6'h35, 8'h04);
      tick(2);
      chk(16'(o_incl), 16'(raw));
      $display("test rotation done");
      wr(6'h34, 8'h00);
      for (int i = 0; i < 8; i++) begin
         {i_alarm_oe, i_alarm_out, i_gpio_oe, i_gpio_out} = 8'($urandom);
         tick(2);
         for (int p = 0; p < 2; p++) chk(pin(p), mux(p));
      end
      $display("test priority done");
      src_en = 1'b1;
      tick(100);
      for (int m = 0; m < 4; m++) begin
         sel = m & 1;
         pol = m >> 1;
         {i_alarm_oe, i_alarm_out, i_gpio_oe, i_gpio_out} = 8'($urandom);
         wr(6'h34, 8'(4 + m));
         wait_for(1, sel, !pol, n);
         wait_for(1, sel, pol, n);
         wait_for(1, sel, !pol, n);
         chk(16'(n >= 6 && n <= 14), 16'h0001);
         chk(pin(1 - sel), mux(1 - sel));
      end
      wr(6'h34, 8'h05);
      tick(2);
      chk(pin(0), mux(0));
      wr(6'h34, 8'h01);
      tick(2);
      chk(pin(1), mux(1));
      src_en = 1'b0;
      $display("test data ready done");
      wr(6'h34, 8'h05);
      wr(6'h35, 8'h01);
      wait_for(0, 0, 1'b1, n);
      wait_for(0, 0, 1'b0, n);
      wait_for(0, 0, 1'b1, n);
      chk(16'(n < 4), 16'h0001);
      sw_rst();
      rd(6'h35, 8'h00);
      rd(6'h34, 8'h05);
      repeat (2) begin
         wait_for(0, 0, 1'b0, n);
         tick(4);
      end
      chk(16'(o_self_check_fail), 16'h0001);
      i_low_power = 1'b1;
      i_self_check_ok = 1'b1;
      sw_rst();
      wait_for(0, 0, 1'b1, n);
      wait_for(0, 0, 1'b0, n);
      chk(16'(n), 16'(LP));
      tick(2);
      chk(16'(o_self_check_fail), 16'h0000);
      wr(6'h35, 8'h04);
      sw_rst();
      repeat (10) begin
         tick(1);
         chk(16'(o_self_check_active), 16'h0000);
      end
      $display("test self check done");
      complete_run();
   end
endmodule // mfc_misc_ctrl_tb
